// *** hw/slp_pkg.sv ***
/*
 * Constants for the sector lock protection block: command codes, field
 * positions, register reset values and operation timings.
 * Assumes a single 200 MHz system clock and a command decoder outside.
 */
package slp_pkg;
    // ------------------------------------------------------------
    // Commands taken on the command port
    // ------------------------------------------------------------
    localparam logic [3:0] SLP_CMD_RD_NVLOCK = 4'h0;
    localparam logic [3:0] SLP_CMD_WR_NVLOCK = 4'h1;
    localparam logic [3:0] SLP_CMD_ER_NVLOCK = 4'h2;
    localparam logic [3:0] SLP_CMD_RD_VLOCK = 4'h3;
    localparam logic [3:0] SLP_CMD_WR_VLOCK = 4'h4;
    localparam logic [3:0] SLP_CMD_RD_PMR = 4'h5;
    localparam logic [3:0] SLP_CMD_WR_PMR = 4'h6;
    localparam logic [3:0] SLP_CMD_RD_FREEZE = 4'h7;
    localparam logic [3:0] SLP_CMD_WR_FREEZE = 4'h8;
    localparam logic [3:0] SLP_CMD_SW_RESET = 4'h9;

    // ------------------------------------------------------------
    // Field positions and values
    // ------------------------------------------------------------
    localparam int SLP_VL_WP_BIT = 0;
    localparam int SLP_VL_LD_BIT = 1;
    localparam int SLP_PMR_ERASE_LOCK_BIT = 0;
    localparam int SLP_PMR_NV_LOCKDOWN_BIT = 1;
    localparam int SLP_PMR_LOCKDOWN_BIT = 2;
    localparam int SLP_FSR_PROG_ERR_BIT = 4;
    localparam int SLP_FSR_PROT_ERR_BIT = 1;
    localparam logic [7:0] SLP_NV_LOCKED_BYTE = 8'h00;
    localparam logic [7:0] SLP_NV_UNLOCKED_BYTE = 8'hFF;
    localparam logic [7:0] SLP_PMR_RESET = 8'hFF;
    localparam logic [7:0] SLP_VL_MASK = 8'h03;
    localparam logic [7:0] SLP_ZERO_BYTE = 8'h00;

    // ------------------------------------------------------------
    // Timing: typical byte program and sector erase, in ns
    // ------------------------------------------------------------
    localparam int SLP_CLK_PERIOD_NS = 5;
    localparam int SLP_T_BYTE_PROG_NS = 30000;
    localparam int SLP_T_SECT_ERASE_NS = 250000;
    localparam int SLP_BYTE_PROG_CYC = SLP_T_BYTE_PROG_NS / SLP_CLK_PERIOD_NS;
    localparam int SLP_SECT_ERASE_CYC = SLP_T_SECT_ERASE_NS / SLP_CLK_PERIOD_NS;

    typedef enum logic [1:0] {SLP_IDLE, SLP_PROG, SLP_ERASE} slp_state_type;
endpackage

// *** hw/slp_sector_lock.sv ***
/*
 * Sector lock protection: per-sector nonvolatile lock array, per-sector
 * volatile lock registers, protection management register, global freeze
 * bit, and the program/erase permission check for the main array.
 * Assumes an outside decoder that has already checked write enable and
 * hands over one command at a time as a one-cycle strobe.
 */
// Overview of operation
// [RQ1] A nonvolatile lock bit of 0 blocks program and erase in that sector.
// [RQ2] Nonvolatile lock state lives in flash cells; erased unlocked, programmed locked.
// [RQ3] Lock bits program to 0 singly; only a group erase returns them to 1.
// [RQ4] Programming one lock bit keeps the block busy one byte-program time.
// [RQ5] Erase sets all lock bits to 1, busy one sector-erase time.
// [RQ6] Reading a nonvolatile lock entry returns 00h locked, FFh unlocked.
// [RQ7] Each sector has an 8-bit volatile lock register, readable and writable.
// [RQ8] A volatile write-protect bit of 1 blocks program and erase there.
// [RQ9] Reset clears every volatile lock bit to 0.
// [RQ10] Both volatile bits come up 0 so they can later be set.
// [RQ11] Lock-down set to 1 rejects writes to both volatile bits until reset.
// [RQ12] Volatile lock write executes only while lock-down bit 1 is 0.
// [RQ13] The management register has dedicated read and write commands.
// [RQ14] Management bit 2 at 0 makes writes to that register be ignored.
// [RQ15] A rejected management write sets flag status bits 1 and 4.
// [RQ16] Host should clear management bit 2 if enhanced security is unused.
// [RQ17] Global freeze at 0 refuses program and erase of lock bits.
// [RQ18] Management bit 1 at 0 refuses lock-bit program and erase forever.
// [RQ19] Lock array erase needs management bit 0 still at 1.
// [RQ20] A sector is protected when its lock bit is 0 or write-protect is 1.
`timescale 1ns/1ps
`default_nettype none
module slp_sector_lock
    import slp_pkg::*;
#(
    parameter int NUM_SECTORS = 256,
    parameter int SECT_W = 8,
    parameter int PROG_CYCLES = SLP_BYTE_PROG_CYC,
    parameter int ERASE_CYCLES = SLP_SECT_ERASE_CYC
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_code,
    input wire logic [SECT_W-1:0] cmd_sector,
    input wire logic [7:0] cmd_data,
    input wire logic fsr_clear,
    input wire logic chk_valid,
    input wire logic [SECT_W-1:0] chk_sector,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic busy,
    output logic chk_allow,
    output logic [7:0] flag_status
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Nonvolatile array survives sys_rst: only erase and program change it
    logic [NUM_SECTORS-1:0] nv_lock_reg = '1;
    logic [NUM_SECTORS-1:0] vl_wp_reg;
    logic [NUM_SECTORS-1:0] vl_ld_reg;
    logic [7:0] pmr_reg = SLP_PMR_RESET;
    logic freeze_reg;
    logic [7:0] fsr_reg;
    slp_state_type state_reg;
    logic [31:0] timer_reg;
    logic [SECT_W-1:0] op_sector_reg;
    logic busy_reg;
    // The timer is wide enough for the longest erase at this clock rate.
    // The lock array and the management register carry no reset, since
    // real cells keep their charge across any reset.

    // Sector protected by either scheme
    function automatic logic sector_protected(input logic nv_bit, input logic wp_bit);
        return !nv_bit || wp_bit; // RQ20
    endfunction

    // Command decode. A command is only taken while the sequencer is idle,
    // so a strobe that comes during a timed operation is lost: the host
    // must poll busy rather than queue behind it.
    // Refusals are decoded once here so flags and checks agree.
    wire logic nv_change_ok = freeze_reg && pmr_reg[SLP_PMR_NV_LOCKDOWN_BIT]; // RQ17 RQ18
    wire logic cmd_take = cmd_valid && !busy_reg;
    wire logic do_nv_prog = cmd_take && cmd_code == SLP_CMD_WR_NVLOCK && nv_change_ok;
    wire logic do_nv_erase = cmd_take && cmd_code == SLP_CMD_ER_NVLOCK && nv_change_ok
        && pmr_reg[SLP_PMR_ERASE_LOCK_BIT]; // RQ19
    wire logic pmr_refused = cmd_take && cmd_code == SLP_CMD_WR_PMR && !pmr_reg[SLP_PMR_LOCKDOWN_BIT]; // RQ14
    wire logic nv_refused = cmd_take && (cmd_code == SLP_CMD_WR_NVLOCK || cmd_code == SLP_CMD_ER_NVLOCK)
        && !do_nv_prog && !do_nv_erase;
    wire logic sw_reset = cmd_take && cmd_code == SLP_CMD_SW_RESET;

    // ------------------------------------------------------------
    // Lock-bit program/erase sequencer
    // ------------------------------------------------------------
    // Cell contents change only at the end of the timed operation, as real cells do
    // The timer loads count minus one and spends its last cycle at zero,
    // so busy covers the taking cycle plus the whole count.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_reg <= SLP_IDLE;
            timer_reg <= '0;
            op_sector_reg <= '0;
            busy_reg <= 1'b0;
        end else begin
            case (state_reg)
                SLP_IDLE: begin
                    if (do_nv_prog) begin
                        state_reg <= SLP_PROG;
                        timer_reg <= 32'(PROG_CYCLES - 1); // RQ4
                        op_sector_reg <= cmd_sector;
                        busy_reg <= 1'b1;
                    end else if (do_nv_erase) begin
                        state_reg <= SLP_ERASE;
                        timer_reg <= 32'(ERASE_CYCLES - 1); // RQ5
                        busy_reg <= 1'b1;
                    end
                end
                SLP_PROG, SLP_ERASE: begin
                    if (timer_reg == '0) begin
                        state_reg <= SLP_IDLE;
                        busy_reg <= 1'b0;
                    end else begin
                        timer_reg <= timer_reg - 32'd1;
                    end
                end
                default: begin
                    state_reg <= SLP_IDLE;
                    busy_reg <= 1'b0;
                end
            endcase
        end
    end

    // Nonvolatile cells: program clears one bit, erase sets all; no reset
    always_ff @(posedge sys_clk) begin
        if (timer_reg == '0 && state_reg == SLP_PROG) begin
            nv_lock_reg[op_sector_reg] <= 1'b0; // RQ2 RQ3
        end else if (timer_reg == '0 && state_reg == SLP_ERASE) begin
            nv_lock_reg <= '1; // RQ5
        end
    end

    // ------------------------------------------------------------
    // Volatile lock registers and freeze bit
    // ------------------------------------------------------------
    // Lock-down is tested before the write, so one write may set lock-down
    // and write-protect together; nothing moves them again until reset.
    always_ff @(posedge sys_clk) begin
        if (sys_rst || sw_reset) begin
            vl_wp_reg <= '0; // RQ9 RQ10
            vl_ld_reg <= '0; // RQ9 RQ10
            freeze_reg <= 1'b1;
        end else if (cmd_take) begin
            if (cmd_code == SLP_CMD_WR_VLOCK && !vl_ld_reg[cmd_sector]) begin // RQ11 RQ12
                vl_wp_reg[cmd_sector] <= cmd_data[SLP_VL_WP_BIT]; // RQ7
                vl_ld_reg[cmd_sector] <= cmd_data[SLP_VL_LD_BIT];
            end
            if (cmd_code == SLP_CMD_WR_FREEZE) begin
                freeze_reg <= freeze_reg & cmd_data[0];
            end
        end
    end

    // Management register: OTP, bits only ever go 1 to 0; survives reset
    always_ff @(posedge sys_clk) begin
        if (cmd_take && cmd_code == SLP_CMD_WR_PMR && pmr_reg[SLP_PMR_LOCKDOWN_BIT]) begin
            pmr_reg <= pmr_reg & cmd_data; // RQ13
        end
    end

    // Flag status errors; a new error wins over a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            fsr_reg <= SLP_ZERO_BYTE;
        end else if (pmr_refused || nv_refused) begin
            fsr_reg[SLP_FSR_PROT_ERR_BIT] <= 1'b1; // RQ15
            fsr_reg[SLP_FSR_PROG_ERR_BIT] <= 1'b1; // RQ15
        end else if (fsr_clear) begin
            fsr_reg <= SLP_ZERO_BYTE;
        end
    end

    // ------------------------------------------------------------
    // Read answers and permission check, all registered
    // ------------------------------------------------------------
    // Read data is captured on the taking edge and then held;
    // only rsp_valid marks a fresh answer.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rsp_valid <= 1'b0;
            rsp_data <= SLP_ZERO_BYTE;
        end else begin
            rsp_valid <= 1'b0;
            if (cmd_take) begin
                case (cmd_code)
                    SLP_CMD_RD_NVLOCK: begin
                        rsp_valid <= 1'b1;
                        rsp_data <= nv_lock_reg[cmd_sector] ? SLP_NV_UNLOCKED_BYTE : SLP_NV_LOCKED_BYTE; // RQ6
                    end
                    SLP_CMD_RD_VLOCK: begin
                        rsp_valid <= 1'b1;
                        rsp_data <= {6'h00, vl_ld_reg[cmd_sector], vl_wp_reg[cmd_sector]} & SLP_VL_MASK; // RQ7
                    end
                    SLP_CMD_RD_PMR: begin
                        rsp_valid <= 1'b1;
                        rsp_data <= pmr_reg; // RQ13
                    end
                    SLP_CMD_RD_FREEZE: begin
                        rsp_valid <= 1'b1;
                        rsp_data <= {7'h00, freeze_reg};
                    end
                    default: begin
                        rsp_valid <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Permission answer for the main-array program/erase path
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            chk_allow <= 1'b0;
        end else if (chk_valid) begin
            chk_allow <= !sector_protected(nv_lock_reg[chk_sector], vl_wp_reg[chk_sector]); // RQ1 RQ8 RQ20
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            busy <= 1'b0;
            flag_status <= SLP_ZERO_BYTE;
        end else begin
            busy <= busy_reg || do_nv_prog || do_nv_erase;
            flag_status <= fsr_reg;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Flags reach the output two edges after a refusal: fsr_reg, then flag_status
    chk_pmr_refuse_flags: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ15
        pmr_refused |=> ##1 (flag_status[SLP_FSR_PROT_ERR_BIT] && flag_status[SLP_FSR_PROG_ERR_BIT]))
        else $error("refused management write left flags clear");

    // Refused lock-array commands raise the same pair of flags
    chk_nv_refuse_flags: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ15
        nv_refused |=> ##1 (flag_status[SLP_FSR_PROT_ERR_BIT] && flag_status[SLP_FSR_PROG_ERR_BIT]))
        else $error("refused lock-array command left flags clear");

    // Once sealed, the management register never moves again
    chk_pmr_frozen: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ14
        !pmr_reg[SLP_PMR_LOCKDOWN_BIT] |=> $stable(pmr_reg))
        else $error("locked management register changed");

    // Management bits are one-time programmable: none returns to 1
    chk_pmr_otp: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ13
        1'b1 |=> (pmr_reg & ~$past(pmr_reg)) == SLP_ZERO_BYTE)
        else $error("management bit returned to one");

    // A write aimed at a locked-down sector moves no volatile bit
    chk_vl_lockdown_hold: assert property (@(posedge sys_clk) disable iff (sys_rst || sw_reset) // RQ11
        vl_ld_reg[cmd_sector] && cmd_take |=> $stable(vl_wp_reg) && $stable(vl_ld_reg))
        else $error("locked-down volatile bits changed");

    // A write to an open sector lands in its write-protect bit
    chk_vl_write: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ12
        cmd_take && cmd_code == SLP_CMD_WR_VLOCK && !vl_ld_reg[cmd_sector]
            |=> vl_wp_reg[$past(cmd_sector)] == $past(cmd_data[SLP_VL_WP_BIT]))
        else $error("volatile lock write lost");

    // Hardware reset clears every volatile bit
    chk_vl_reset_clear: assert property (@(posedge sys_clk) // RQ9
        sys_rst |=> vl_wp_reg == '0 && vl_ld_reg == '0)
        else $error("volatile bits not cleared by reset");

    // Software reset releases lock-down and the freeze bit as well
    chk_sw_reset_clear: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ11
        sw_reset |=> vl_wp_reg == '0 && vl_ld_reg == '0 && freeze_reg)
        else $error("software reset left volatile state set");

    // Reserved volatile bits always read 0
    chk_vl_read: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ7
        cmd_take && cmd_code == SLP_CMD_RD_VLOCK |=> rsp_valid && (rsp_data & ~SLP_VL_MASK) == SLP_ZERO_BYTE)
        else $error("volatile read shows reserved bits");

    // Either scheme alone is enough to block the main array
    chk_allow_protect: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ20
        chk_valid && (!nv_lock_reg[chk_sector] || vl_wp_reg[chk_sector]) |=> !chk_allow)
        else $error("protected sector allowed");

    // Lock-array gating by freeze and management bits
    chk_freeze_block: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ17
        !freeze_reg && cmd_take |-> !do_nv_prog && !do_nv_erase)
        else $error("lock bit change while frozen");

    chk_nv_lockdown: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ18
        !pmr_reg[SLP_PMR_NV_LOCKDOWN_BIT] |-> !do_nv_prog && !do_nv_erase)
        else $error("lock bit change after lock-array lockdown");

    chk_erase_lock: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ19
        !pmr_reg[SLP_PMR_ERASE_LOCK_BIT] |-> !do_nv_erase)
        else $error("lock array erased while erase locked");

    // Timed operations hold busy and land at the end of the count
    chk_prog_busy: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ4
        do_nv_prog |=> busy [*2])
        else $error("lock bit program not busy");

    chk_erase_busy: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ5
        do_nv_erase |=> busy [*8])
        else $error("lock array erase not busy");

    chk_prog_lands: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ3
        state_reg == SLP_PROG && timer_reg == '0 |=> !nv_lock_reg[$past(op_sector_reg)])
        else $error("lock bit program did not land");

    chk_erase_lands: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ5
        state_reg == SLP_ERASE && timer_reg == '0 |=> nv_lock_reg == '1)
        else $error("lock array erase did not land");

    // A read issued while busy is dropped, not answered late
    chk_busy_drop: assert property (@(posedge sys_clk) disable iff (sys_rst)
        busy_reg && cmd_valid |=> !rsp_valid)
        else $error("command taken while busy");

    // Lock entries read as whole bytes, never a mix
    chk_nv_read: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ6
        cmd_take && cmd_code == SLP_CMD_RD_NVLOCK |=> rsp_valid
            && (rsp_data == SLP_NV_LOCKED_BYTE || rsp_data == SLP_NV_UNLOCKED_BYTE))
        else $error("bad lock entry read");

    // Every output comes out of reset idle
    chk_reset_outputs: assert property (@(posedge sys_clk)
        sys_rst |=> !busy && !rsp_valid && !chk_allow && flag_status == SLP_ZERO_BYTE)
        else $error("outputs not idle after reset");

    // ------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------
    cov_nv_prog: cover property (@(posedge sys_clk) do_nv_prog);
    cov_nv_erase: cover property (@(posedge sys_clk) do_nv_erase);
    cov_pmr_refused: cover property (@(posedge sys_clk) pmr_refused);
    cov_blocked: cover property (@(posedge sys_clk) chk_valid ##1 !chk_allow);
    cov_vl_lockdown: cover property (@(posedge sys_clk) cmd_take && vl_ld_reg[cmd_sector]);
endmodule
`default_nettype wire

// *** testbench/sector_lock_protection_test.sv ***
/* Self-checking bench for the sector lock block, with the host model in front.
   Assumes management register and lock array power up all ones. */
`timescale 1ns/1ps
`default_nettype none
module sector_lock_protection_test
    import slp_pkg::*;
;
    // ------------------------------------------------------------
    // Bench signals, clock, reset and timeout
    // ------------------------------------------------------------
    localparam logic [7:0] ERRS = (8'h01 << SLP_FSR_PROT_ERR_BIT) | (8'h01 << SLP_FSR_PROG_ERR_BIT);
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_valid, fsr_clear, chk_valid, rsp_valid, busy, chk_allow, got, allow;
    logic [3:0] cmd_code;
    logic [7:0] cmd_sector, cmd_data, chk_sector, rsp_data, flag_status, rd, protection_management_reg;
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;
    int n;
    // Short counts keep the run brief; expectations follow them
    localparam int PROG_CYC = 4;
    localparam int ERASE_CYC = 8;
    slp_sector_lock #(.PROG_CYCLES(PROG_CYC), .ERASE_CYCLES(ERASE_CYC)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_sector(cmd_sector), .cmd_data(cmd_data),
        .fsr_clear(fsr_clear), .chk_valid(chk_valid), .chk_sector(chk_sector), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .busy(busy), .chk_allow(chk_allow), .flag_status(flag_status));
    slp_host_model host (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_sector(cmd_sector), .cmd_data(cmd_data), .fsr_clear(fsr_clear), .chk_valid(chk_valid),
        .chk_sector(chk_sector), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .chk_allow(chk_allow));
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    // A hang ends the run as a failure
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            test_done();
        end
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Read command that must answer with the given byte
    task automatic rd_chk(input string what, input logic [3:0] c, input logic [7:0] s, input logic [7:0] e);
        host.cmd(c, s, 8'h00, got, rd);
        check({what, " valid"}, {7'h00, got}, 8'h01);
        check(what, rd, e);
    endtask
    task automatic allow_chk(input logic [7:0] s, input logic e);
        host.chk(s, allow);
        check("allow", {7'h00, allow}, {7'h00, e});
    endtask
    // Count busy cycles, bounded
    task automatic busy_len(output int len);
        len = 0;
        while (busy === 1'b1 && len < 100) begin
            len++;
            @(negedge sys_clk);
        end
    endtask
    // Refused lock-array or management command: no busy, both error flags, then clear
    task automatic refused(input logic [3:0] c, input logic [7:0] d);
        host.cmd(c, 8'h09, d, got, rd);
        check("busy", {7'h00, busy}, 8'h00);
        repeat (3) @(negedge sys_clk);
        check("flags", flag_status, ERRS);
        host.clr();
        repeat (3) @(negedge sys_clk);
        check("flags cleared", flag_status, 8'h00);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_volatile();
        rd_chk("vlock", SLP_CMD_RD_VLOCK, 8'h03, 8'h00);
        check("flags", flag_status, 8'h00);
        host.cmd(SLP_CMD_WR_VLOCK, 8'h03, 8'h01, got, rd);
        rd_chk("vlock", SLP_CMD_RD_VLOCK, 8'h03, 8'h01);
        allow_chk(8'h03, 1'b0);
        allow_chk(8'h04, 1'b1);
        host.cmd(SLP_CMD_WR_VLOCK, 8'h03, 8'h03, got, rd);
        host.cmd(SLP_CMD_WR_VLOCK, 8'h03, 8'h00, got, rd);
        rd_chk("vlock", SLP_CMD_RD_VLOCK, 8'h03, 8'h03);
        host.cmd(SLP_CMD_SW_RESET, 8'h00, 8'h00, got, rd);
        rd_chk("vlock", SLP_CMD_RD_VLOCK, 8'h03, 8'h00);
    endtask
    task automatic t_nonvolatile();
        rd_chk("nvlock", SLP_CMD_RD_NVLOCK, 8'h05, SLP_NV_UNLOCKED_BYTE);
        host.cmd(SLP_CMD_WR_NVLOCK, 8'h05, 8'h00, got, rd);
        busy_len(n);
        // Busy stands count plus one cycles; one of them passes inside the command
        check("prog busy", n[7:0], 8'(PROG_CYC));
        rd_chk("nvlock", SLP_CMD_RD_NVLOCK, 8'h05, SLP_NV_LOCKED_BYTE);
        rd_chk("nvlock", SLP_CMD_RD_NVLOCK, 8'h06, SLP_NV_UNLOCKED_BYTE);
        allow_chk(8'h05, 1'b0);
        host.cmd(SLP_CMD_WR_NVLOCK, 8'h07, 8'h00, got, rd);
        host.cmd(SLP_CMD_RD_PMR, 8'h00, 8'h00, got, rd);
        check("dropped read", {7'h00, got}, 8'h00);
        busy_len(n);
        host.cmd(SLP_CMD_ER_NVLOCK, 8'h00, 8'h00, got, rd);
        busy_len(n);
        check("erase busy", n[7:0], 8'(ERASE_CYC));
        rd_chk("nvlock", SLP_CMD_RD_NVLOCK, 8'h05, SLP_NV_UNLOCKED_BYTE);
        allow_chk(8'h05, 1'b1);
    endtask
    task automatic t_freeze();
        host.cmd(SLP_CMD_WR_FREEZE, 8'h00, 8'h00, got, rd);
        rd_chk("freeze", SLP_CMD_RD_FREEZE, 8'h00, 8'h00);
        refused(SLP_CMD_WR_NVLOCK, 8'h00);
        rd_chk("nvlock", SLP_CMD_RD_NVLOCK, 8'h09, SLP_NV_UNLOCKED_BYTE);
        host.cmd(SLP_CMD_SW_RESET, 8'h00, 8'h00, got, rd);
        rd_chk("freeze", SLP_CMD_RD_FREEZE, 8'h00, 8'h01);
    endtask
    // Management bits only ever go from 1 to 0, so this runs last
    task automatic t_pmr();
        protection_management_reg = SLP_PMR_RESET;
        rd_chk("pmr", SLP_CMD_RD_PMR, 8'h00, protection_management_reg);
        protection_management_reg = protection_management_reg & ~(8'h01 << SLP_PMR_ERASE_LOCK_BIT);
        host.cmd(SLP_CMD_WR_PMR, 8'h00, protection_management_reg, got, rd);
        refused(SLP_CMD_ER_NVLOCK, 8'h00);
        protection_management_reg = protection_management_reg & ~(8'h01 << SLP_PMR_NV_LOCKDOWN_BIT);
        host.cmd(SLP_CMD_WR_PMR, 8'h00, ~(8'h01 << SLP_PMR_NV_LOCKDOWN_BIT), got, rd);
        rd_chk("pmr", SLP_CMD_RD_PMR, 8'h00, protection_management_reg);
        refused(SLP_CMD_WR_NVLOCK, 8'h00);
        host.seal_pmr();
        protection_management_reg = protection_management_reg & ~(8'h01 << SLP_PMR_LOCKDOWN_BIT);
        refused(SLP_CMD_WR_PMR, 8'h00);
        rd_chk("pmr", SLP_CMD_RD_PMR, 8'h00, protection_management_reg);
    endtask
    task automatic test_done();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (16) @(negedge sys_clk);
        sys_rst = 1'b0;
        t_volatile();
        t_nonvolatile();
        t_freeze();
        t_pmr();
        test_done();
    end
endmodule
`default_nettype wire

// *** testbench/slp_host_model.sv ***
/* Host model: drives commands, sector checks and flag clears into the lock
   block and samples its answers. Assumes the bench waits out busy itself. */
`timescale 1ns/1ps
`default_nettype none
module slp_host_model
    import slp_pkg::*;
(
    input wire logic sys_clk,
    output logic cmd_valid,
    output logic [3:0] cmd_code,
    output logic [7:0] cmd_sector,
    output logic [7:0] cmd_data,
    output logic fsr_clear,
    output logic chk_valid,
    output logic [7:0] chk_sector,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic chk_allow
);
    // ------------------------------------------------------------
    // Host transfers, all launched on the falling edge
    // ------------------------------------------------------------
    // Idle values at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 4'hF;
        cmd_sector = 8'h00;
        cmd_data = 8'h00;
        fsr_clear = 1'b0;
        chk_valid = 1'b0;
        chk_sector = 8'h00;
    end
    // Sector and data flip when the strobe drops so a stale value never looks held; the code stays
    task automatic cmd(input logic [3:0] code, input logic [7:0] sect, input logic [7:0] data,
        output logic got, output logic [7:0] rdat);
        @(negedge sys_clk);
        cmd_code = code;
        cmd_sector = sect;
        cmd_data = data;
        cmd_valid = 1'b1;
        @(negedge sys_clk);
        // The read answer stands only in the cycle after the taking edge
        got = rsp_valid;
        rdat = rsp_data;
        cmd_valid = 1'b0;
        cmd_sector = ~sect;
        cmd_data = ~data;
        @(negedge sys_clk);
    endtask
    // Ask whether a sector may be modified; answer one cycle later
    task automatic chk(input logic [7:0] sect, output logic allow);
        @(negedge sys_clk);
        chk_sector = sect;
        chk_valid = 1'b1;
        @(negedge sys_clk);
        chk_valid = 1'b0;
        chk_sector = ~sect;
        @(negedge sys_clk);
        allow = chk_allow;
    endtask
    // One-cycle flag clear pulse
    task automatic clr();
        @(negedge sys_clk);
        fsr_clear = 1'b1;
        @(negedge sys_clk);
        fsr_clear = 1'b0;
    endtask
    // Seal the management register when enhanced security is unused
    task automatic seal_pmr();
        logic g;
        logic [7:0] d;
        cmd(SLP_CMD_WR_PMR, 8'h00, ~(8'h01 << SLP_PMR_LOCKDOWN_BIT), g, d);
    endtask
endmodule
`default_nettype wire
